// File: src/io_ports_status.sv
// The implementer's own choice: the Wishbone register port.
`timescale 1ns/1ps
// Behaviour
// - Input-only lines have no driver; reads give pin level, writes ignored.
// - Any analog input selectable; sampled for 4 state times at conversion start.
// - Quasi line: weak pullup always on, pulldown only while latch bit is zero.
// - Latch zero-to-one turns on strong pullup for exactly one state time.
// - Quasi port writes go to latch; reads return sensed pin levels.
// - Output-only lines have no input buffer; pin level not readable.
// - Access pin low means shared pins always bus; else only during accesses.
// - Shared latches reset to all ones; rewrite ones before reading input.
// - Port use drives open-drain pulldown only; bus use drives both levels.
// - Shared word low byte is third port (bus 0-7), high byte fourth (8-15).
// - First control register enables four capture inputs, picks timer two sources.
// - Second control picks pulse-width or plain bit, serial or plain bit.
// - Second control bit picks external interrupt pin or analog channel seven.
// - Second control holds timer one and timer two overflow interrupt enables.
// - Second control bit fires capture interrupt at one or seven queue entries.
// - Second control enables output lines four and five to output unit.
// - Read at first control address returns first status register.
// - Second status: timers bits 0-3, overflows 4 and 5, queue 6 and 7.
// - Reading second status clears bits 5 to 0; bits 6 and 7 untouched.
// - Implicit reads clear the time flags just like explicit loads.
module io_ports_status (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [15:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic [7:0] p0_pin_i,
  input wire logic [7:0] p1_pin_i,
  input wire logic [7:0] p2_pin_i,
  input wire logic [15:0] ad_pin_i,
  input wire logic external_access_n_i,
  input wire logic bus_access_i,
  input wire logic bus_drive_i,
  input wire logic [15:0] bus_data_i,
  input wire logic txd_i,
  input wire logic pwm_i,
  input wire logic conv_start_i,
  input wire logic [7:0] io_status_zero_i,
  input wire logic [3:0] soft_timer_i,
  input wire logic t1_ovf_i,
  input wire logic t2_ovf_i,
  input wire logic hsi_full_i,
  input wire logic hsi_avail_i,
  input wire logic [2:0] hsi_count_i,
  output logic [9:0] quasi_pull_low_o,
  output logic [9:0] quasi_strong_up_o,
  output logic p2_txd_pin_o,
  output logic p2_pwm_pin_o,
  output logic [15:0] ad_o,
  output logic [15:0] ad_oe_n_o,
  output logic [7:0] adc_sample_o,
  output logic [3:0] hsi_enable_o,
  output logic [3:0] timer2_cfg_o,
  output logic ext_int_o,
  output logic hsi_int_o,
  output logic t1_ovf_irq_o,
  output logic t2_ovf_irq_o,
  output logic hso4_en_o,
  output logic hso5_en_o
);
  logic [40:0] sync1;
  logic [40:0] sync2;
  logic [7:0] ctl_zero;
  logic [7:0] ctl_one;
  logic [5:0] time_flags;
  logic [7:0] p1_latch;
  logic [7:0] p2_latch;
  logic [15:0] shared_latch;
  logic [2:0] adc_chan;
  logic [1:0] tick_cnt;
  logic tick;
  logic [9:0] rise_pend;
  logic [9:0] quasi_prev;
  logic conv_pend;
  logic [2:0] sample_left;

  // Synchronised pin levels
  wire [7:0] p0_s = sync2[7:0];
  wire [7:0] p1_s = sync2[15:8];
  wire [7:0] p2_s = sync2[23:16];
  wire [15:0] ad_s = sync2[39:24];
  wire ea_n_s = sync2[40];

  // Bus decode
  // Only lanes 0 and 1 carry data; the upper half of the bus word is ignored
  wire [13:0] idx = adr_i[15:2];
  wire take = cyc_i & stb_i & ~ack_o;
  wire wr = take & we_i;
  wire rd = take & ~we_i;
  wire wr_lo = wr & sel_i[0];
  wire wr_hi = wr & sel_i[1];
  wire hit_ctl0 = idx == io_ports_pkg::IDX_IO_ZERO;
  wire hit_ctl1 = idx == io_ports_pkg::IDX_IO_ONE;
  wire clr_time = rd & hit_ctl1;
  wire [9:0] quasi_latch = {p2_latch[7:6], p1_latch};
  wire [7:0] io_status_one = {hsi_avail_i, hsi_full_i, time_flags};
  wire [5:0] time_events = {t1_ovf_i, t2_ovf_i, soft_timer_i};
  wire bus_mode = ~ea_n_s | bus_access_i;
  wire [2:0] hsi_level = ctl_one[io_ports_pkg::C1_HSI7] ? io_ports_pkg::HSI_SEVEN : io_ports_pkg::HSI_ONE;

  // Read data: output-only bits come from the latch, since no input buffer exists
  // Unmapped indices read zero so software never sees a floating bus
  wire [7:0] p2_read = (p2_latch & io_ports_pkg::P2_OUT_MASK) | (p2_s & ~io_ports_pkg::P2_OUT_MASK);
  wire [15:0] rd_mux =
    (idx == io_ports_pkg::IDX_PORT0) ? {8'h00, p0_s} :
    (idx == io_ports_pkg::IDX_PORT1) ? {8'h00, p1_s} :
    (idx == io_ports_pkg::IDX_PORT2) ? {8'h00, p2_read} :
    (idx == io_ports_pkg::IDX_ADC_SEL) ? {13'h0000, adc_chan} :
    hit_ctl0 ? {8'h00, io_status_zero_i} :
    hit_ctl1 ? {8'h00, io_status_one} :
    (idx == io_ports_pkg::IDX_SHARED) ? ad_s : 16'h0000;

  // Two flops on every pin; only the second stage is read
  // Costs two clocks of latency on every pin read, traded for metastability margin
  always_ff @(posedge clk_i) begin
    sync1 <= {external_access_n_i, ad_pin_i, p2_pin_i, p1_pin_i, p0_pin_i};
    sync2 <= sync1;
  end

  // Wishbone answer: ack one cycle after the request, unmapped reads give zero
  // The ack term in take stops a held request from being taken twice
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= take;
      if (rd) begin
        dat_o <= {16'h0000, rd_mux};
      end
    end
  end

  // Control registers and port latches; writes to the input port have no target
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_zero <= io_ports_pkg::RST_CTL_ZERO;
      ctl_one <= io_ports_pkg::RST_CTL_ONE;
      p1_latch <= io_ports_pkg::RST_QUASI;
      p2_latch <= io_ports_pkg::RST_QUASI;
      shared_latch <= io_ports_pkg::RST_SHARED;
      adc_chan <= 3'h0;
    end else begin
      if (wr_lo && hit_ctl0) begin
        ctl_zero <= dat_i[7:0];
      end
      if (wr_lo && hit_ctl1) begin
        ctl_one <= dat_i[7:0];
      end
      if (wr_lo && idx == io_ports_pkg::IDX_PORT1) begin
        p1_latch <= dat_i[7:0];
      end
      if (wr_lo && idx == io_ports_pkg::IDX_PORT2) begin
        p2_latch <= dat_i[7:0];
      end
      if (wr_lo && idx == io_ports_pkg::IDX_ADC_SEL) begin
        adc_chan <= dat_i[2:0];
      end
      if (idx == io_ports_pkg::IDX_SHARED) begin
        if (wr_lo) begin
          shared_latch[7:0] <= dat_i[7:0];
        end
        if (wr_hi) begin
          shared_latch[15:8] <= dat_i[15:8];
        end
      end
    end
  end

  // Time flags: an event in the clearing cycle survives the read
  // Set wins over clear, so a timer event landing on the read is never lost
  // Any read of the status index clears, including bit tests by the processor
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      time_flags <= 6'h00;
    end else begin
      time_flags <= (time_flags & ~(clr_time ? io_ports_pkg::TIME_FLAGS : 6'h00)) | time_events;
    end
  end

  // State time divider: one-cycle tick every STATE_CLKS clocks
  // All state-time based timing hangs off this single enable pulse
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_cnt <= 2'h0;
      tick <= 1'b0;
    end else begin
      tick <= tick_cnt == 2'(io_ports_pkg::STATE_CLKS - 1);
      tick_cnt <= (tick_cnt == 2'(io_ports_pkg::STATE_CLKS - 1)) ? 2'h0 : tick_cnt + 2'h1;
    end
  end

  // Quasi lines: strong pullup spans the state time after the rising write
  // The pending bit waits for a state boundary so the pulse is a whole state time
  // A latch that falls again before the boundary cancels the pulse
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      quasi_prev <= {10{1'b1}};
      rise_pend <= 10'h000;
      quasi_strong_up_o <= 10'h000;
      quasi_pull_low_o <= 10'h000;
    end else begin
      quasi_prev <= quasi_latch;
      quasi_pull_low_o <= ~quasi_latch;
      rise_pend <= (tick ? 10'h000 : rise_pend) | (quasi_latch & ~quasi_prev);
      if (tick) begin
        quasi_strong_up_o <= rise_pend & quasi_latch;
      end
    end
  end

  // Converter sampling window: starts at the next state boundary, lasts four
  // Up to one state time of start latency, so the window length stays exact
  // A new start during a window restarts it at the next boundary
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      conv_pend <= 1'b0;
      sample_left <= 3'h0;
      adc_sample_o <= 8'h00;
    end else begin
      if (conv_start_i) begin
        conv_pend <= 1'b1;
      end else if (tick) begin
        conv_pend <= 1'b0;
      end
      if (tick) begin
        if (conv_pend) begin
          sample_left <= 3'(io_ports_pkg::SAMPLE_STATES - 1);
          adc_sample_o <= 8'h01 << adc_chan;
        end else if (sample_left != 3'h0) begin
          sample_left <= sample_left - 3'h1;
        end else begin
          adc_sample_o <= 8'h00;
        end
      end
    end
  end

  // Pin functions, shared bus pins and interrupt sources
  // Every pin-facing output is registered so no decode glitch reaches a pin
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      p2_txd_pin_o <= 1'b1;
      p2_pwm_pin_o <= 1'b1;
      ad_o <= 16'h0000;
      ad_oe_n_o <= 16'hFFFF;
      hsi_enable_o <= 4'h0;
      timer2_cfg_o <= 4'h0;
      ext_int_o <= 1'b0;
      hsi_int_o <= 1'b0;
      t1_ovf_irq_o <= 1'b0;
      t2_ovf_irq_o <= 1'b0;
      hso4_en_o <= 1'b0;
      hso5_en_o <= 1'b0;
    end else begin
      p2_txd_pin_o <= ctl_one[io_ports_pkg::C1_TXD] ? txd_i : p2_latch[0];
      p2_pwm_pin_o <= ctl_one[io_ports_pkg::C1_PWM] ? pwm_i : p2_latch[5];
      // Bus use drives both rails; port use only pulls low, needing external pullups
      ad_o <= bus_mode ? bus_data_i : 16'h0000;
      ad_oe_n_o <= bus_mode ? {16{~bus_drive_i}} : shared_latch;
      hsi_enable_o <= {ctl_zero[6], ctl_zero[4], ctl_zero[2], ctl_zero[0]};
      timer2_cfg_o <= {ctl_zero[7], ctl_zero[5], ctl_zero[3], ctl_zero[1]};
      ext_int_o <= ctl_one[io_ports_pkg::C1_EXT_SRC] ? p0_s[7] : p2_s[2];
      hsi_int_o <= hsi_count_i >= hsi_level;
      t1_ovf_irq_o <= t1_ovf_i & ctl_one[io_ports_pkg::C1_T1_IE];
      t2_ovf_irq_o <= t2_ovf_i & ctl_one[io_ports_pkg::C1_T2_IE];
      hso4_en_o <= ctl_one[io_ports_pkg::C1_HSO4];
      hso5_en_o <= ctl_one[io_ports_pkg::C1_HSO5];
    end
  end

  // Helper: length of each sampling window in clocks
  logic [4:0] win_len;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      win_len <= 5'h00;
    end else begin
      win_len <= (|adc_sample_o) ? win_len + 5'h01 : 5'h00;
    end
  end

  bus_ack_a: assert property (@(posedge clk_i) disable iff (rst_i) ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  time_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    clr_time && time_events == 6'h00 |=> time_flags == 6'h00)
    else $error("time flags not cleared by status read");
  queue_bits_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rd && hit_ctl1 |=> dat_o[7:6] == $past({hsi_avail_i, hsi_full_i}))
    else $error("queue status bits wrong on read");
  strong_span_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(quasi_strong_up_o[0]) |-> quasi_strong_up_o[0][*3] ##1 (!quasi_strong_up_o[0] || $rose(rise_pend[0])))
    else $error("strong pullup not one state time");
  sample_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(|adc_sample_o) |-> $past(win_len) == 5'h0B)
    else $error("sampling window not four state times");
  ext_source_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ctl_one[io_ports_pkg::C1_EXT_SRC] |=> ext_int_o == $past(p0_s[7]))
    else $error("external interrupt source wrong");
  bus_drive_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !ea_n_s |=> ad_oe_n_o == {16{!$past(bus_drive_i)}} && ad_o == $past(bus_data_i))
    else $error("shared pins not on bus with access pin low");
  pulldown_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_lo && idx == io_ports_pkg::IDX_PORT1 |=> ##1 quasi_pull_low_o[7:0] == ~$past(dat_i[7:0], 2))
    else $error("quasi pulldown does not follow latch");

  // Register bus and read path
  bus_answer_a: assert property (@(posedge clk_i) disable iff (rst_i)
    take |=> ack_o)
    else $error("request not answered in one cycle");
  input_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rd && idx == io_ports_pkg::IDX_PORT0 |=> dat_o[7:0] == $past(p0_s))
    else $error("input port read is not the pin level");
  quasi_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rd && idx == io_ports_pkg::IDX_PORT1 |=> dat_o[7:0] == $past(p1_s))
    else $error("quasi port read is not the pin level");
  out_readback_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rd && idx == io_ports_pkg::IDX_PORT2 |=>
    (dat_o[7:0] & io_ports_pkg::P2_OUT_MASK) == ($past(p2_latch) & io_ports_pkg::P2_OUT_MASK))
    else $error("output-only bits not read from latch");
  status_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rd && hit_ctl0 |=> dat_o[7:0] == $past(io_status_zero_i))
    else $error("first status register not returned");
  shared_word_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rd && idx == io_ports_pkg::IDX_SHARED |=> dat_o[15:0] == $past(ad_s))
    else $error("shared word read not from pins");

  // Pin functions and interrupt selects
  pwm_select_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ctl_one[io_ports_pkg::C1_PWM] |=> p2_pwm_pin_o == $past(pwm_i))
    else $error("pulse-width output not on pin");
  txd_select_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !ctl_one[io_ports_pkg::C1_TXD] |=> p2_txd_pin_o == $past(p2_latch[0]))
    else $error("plain output bit not on transmit pin");
  ext_pin_src_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !ctl_one[io_ports_pkg::C1_EXT_SRC] |=> ext_int_o == $past(p2_s[2]))
    else $error("external interrupt pin not selected");
  t1_irq_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !ctl_one[io_ports_pkg::C1_T1_IE] |=> !t1_ovf_irq_o)
    else $error("timer one interrupt not masked");
  t2_irq_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    t2_ovf_i && ctl_one[io_ports_pkg::C1_T2_IE] |=> t2_ovf_irq_o)
    else $error("timer two interrupt missing");
  hsi_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ctl_one[io_ports_pkg::C1_HSI7] && hsi_count_i < 3'h7 |=> !hsi_int_o)
    else $error("capture interrupt below seven entries");
  hso_enable_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ctl_one[io_ports_pkg::C1_HSO4] |=> hso4_en_o)
    else $error("output line four not enabled");
  hsi_enable_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ctl_zero[0] |=> hsi_enable_o[0])
    else $error("capture input zero not enabled");
  open_drain_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !bus_mode |=> ad_o == 16'h0000 && ad_oe_n_o == $past(shared_latch))
    else $error("port use not open drain");

  // Status flags and sampling
  flag_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    |time_events |=> (time_flags & $past(time_events)) == $past(time_events))
    else $error("time event not recorded");
  sample_hot_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(|adc_sample_o) |-> $onehot(adc_sample_o))
    else $error("more than one line sampled");
endmodule

// File: src/io_ports_pkg.sv
package io_ports_pkg;
  // Register indices; the byte address on the bus is four times the index
  localparam logic [13:0] IDX_ADC_SEL = 14'h0002;
  localparam logic [13:0] IDX_PORT0 = 14'h000E;
  localparam logic [13:0] IDX_PORT1 = 14'h000F;
  localparam logic [13:0] IDX_PORT2 = 14'h0010;
  localparam logic [13:0] IDX_IO_ZERO = 14'h0015;
  localparam logic [13:0] IDX_IO_ONE = 14'h0016;
  localparam logic [13:0] IDX_SHARED = 14'h1FFE;
  // Reset values
  localparam logic [7:0] RST_CTL_ZERO = 8'h00;
  localparam logic [7:0] RST_CTL_ONE = 8'h01;
  localparam logic [7:0] RST_QUASI = 8'hFF;
  localparam logic [15:0] RST_SHARED = 16'hFFFF;
  // Second control register fields
  localparam int C1_PWM = 0;
  localparam int C1_EXT_SRC = 1;
  localparam int C1_T1_IE = 2;
  localparam int C1_HSO4 = 4;
  localparam int C1_TXD = 5;
  localparam int C1_T2_IE = 3;
  localparam int C1_HSO5 = 6;
  localparam int C1_HSI7 = 7;
  // Second port lines that are output only
  localparam logic [7:0] P2_OUT_MASK = 8'h21;
  localparam logic [5:0] TIME_FLAGS = 6'h3F;
  // Timing in clocks and state times
  localparam int STATE_CLKS = 3;
  localparam int SAMPLE_STATES = 4;
  localparam logic [2:0] HSI_ONE = 3'h1;
  localparam logic [2:0] HSI_SEVEN = 3'h7;
endpackage

// File: verification/pin_model.sv
`timescale 1ns/1ps
// Far-side circuitry; resistors pull every released line high
module pin_model (
  input wire logic [9:0] pull_low_i,
  input wire logic [7:0] ext_low_i,
  input wire logic [15:0] ad_i,
  input wire logic [15:0] ad_oe_n_i,
  output logic [7:0] p1_pin_o,
  output logic [1:0] p2_quasi_o,
  output logic [15:0] ad_pin_o
);
  // Weak pullup holds high unless either side pulls low
  assign p1_pin_o = ~pull_low_i[7:0] & ~ext_low_i;
  assign p2_quasi_o = ~pull_low_i[9:8];
  // A released line never keeps a stale value: the resistor wins
  assign ad_pin_o = ad_i | ad_oe_n_i;
endmodule

// File: verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic clk_i, rst_i, cyc, stb, we, ack, ea_n, bacc, bdrv, txd, pwm, conv, t1, t2, full, avail;
  logic ptx, ppw, ext, hint, t1i, t2i, h4, h5;
  logic [15:0] adr, bdat, ad, oen, adp;
  logic [31:0] wd, rd, q;
  logic [7:0] p0, p1p, st0, extl, adcs;
  logic [9:0] pl, su;
  logic [5:0] p2lo;
  logic [3:0] sel, swt, hen, t2c;
  logic [2:0] hcnt;
  logic [1:0] pq;
  int err_total = 0;
  int tests_run = 0;
  int cyc_n = 0;

  io_ports_status i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(wd), .dat_o(rd), .ack_o(ack), .p0_pin_i(p0), .p1_pin_i(p1p), .p2_pin_i({pq, p2lo}),
    .ad_pin_i(adp), .external_access_n_i(ea_n), .bus_access_i(bacc), .bus_drive_i(bdrv), .bus_data_i(bdat),
    .txd_i(txd), .pwm_i(pwm), .conv_start_i(conv), .io_status_zero_i(st0), .soft_timer_i(swt), .t1_ovf_i(t1),
    .t2_ovf_i(t2), .hsi_full_i(full), .hsi_avail_i(avail), .hsi_count_i(hcnt), .quasi_pull_low_o(pl),
    .quasi_strong_up_o(su), .p2_txd_pin_o(ptx), .p2_pwm_pin_o(ppw), .ad_o(ad), .ad_oe_n_o(oen),
    .adc_sample_o(adcs), .hsi_enable_o(hen), .timer2_cfg_o(t2c), .ext_int_o(ext), .hsi_int_o(hint),
    .t1_ovf_irq_o(t1i), .t2_ovf_irq_o(t2i), .hso4_en_o(h4), .hso5_en_o(h5));
  pin_model i_pins (.pull_low_i(pl), .ext_low_i(extl), .ad_i(ad), .ad_oe_n_i(oen), .p1_pin_o(p1p),
    .p2_quasi_o(pq), .ad_pin_o(adp));

  // Free-running 50 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // Hang guard; the whole run needs well under a thousand cycles
  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 3000) begin
      err_total++;
      conclude();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One classic cycle; request held until ack is sampled, then one idle cycle; only the hang guard ends a wait
  task automatic wb(input logic w, input logic [13:0] ix, input logic [3:0] s, input logic [31:0] d,
                    output logic [31:0] r);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {ix, 2'h0};
    sel <= s;
    wd <= d;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    r = rd;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic waitc(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic t_quasi;
    int n;
    wb(1'b1, io_ports_pkg::IDX_PORT1, 4'h1, 32'h0, q);
    waitc(2);
    chk("pull_low", 32'h0FF, {22'h0, pl});
    // Second write of ones is no rising change, so no strong pulse
    for (int k = 0; k < 2; k++) begin
      n = 0;
      fork
        wb(1'b1, io_ports_pkg::IDX_PORT1, 4'h1, 32'hFF, q);
        repeat (16) begin
          @(posedge clk_i);
          if (su[0] === 1'b1) n++;
        end
      join
      chk("strong_len", (k == 0) ? 32'h3 : 32'h0, n);
    end
    extl <= 8'h0F;
    waitc(4);
    wb(1'b0, io_ports_pkg::IDX_PORT1, 4'h1, 32'h0, q);
    chk("port1_pins", 32'hF0, q);
    extl <= 8'h00;
    $display("test quasi done");
  endtask

  task automatic t_shared;
    wb(1'b1, io_ports_pkg::IDX_SHARED, 4'h1, 32'h1234, q);
    waitc(4);
    chk("oe_port", 32'hFF34, {16'h0, oen});
    chk("ad_port", 32'h0, {16'h0, ad});
    wb(1'b0, io_ports_pkg::IDX_SHARED, 4'h3, 32'h0, q);
    chk("shared_rd", 32'hFF34, q);
    wb(1'b1, io_ports_pkg::IDX_SHARED, 4'h3, 32'hFFFF, q);
    ea_n <= 1'b0;
    bdrv <= 1'b1;
    bdat <= 16'hA5C3;
    waitc(4);
    chk("ad_bus", 32'hA5C3, {16'h0, ad});
    chk("oe_bus", 32'h0, {16'h0, oen});
    ea_n <= 1'b1;
    bacc <= 1'b1;
    waitc(4);
    chk("oe_acc", 32'h0, {16'h0, oen});
    bacc <= 1'b0;
    waitc(4);
    chk("oe_idle", 32'hFFFF, {16'h0, oen});
    $display("test shared done");
  endtask

  task automatic t_ctl;
    int n;
    int n2;
    wb(1'b1, io_ports_pkg::IDX_IO_ZERO, 4'h1, 32'hA5, q);
    waitc(2);
    chk("ctl0", 32'hC3, {24'h0, t2c, hen});
    st0 <= 8'h96;
    wb(1'b0, io_ports_pkg::IDX_IO_ZERO, 4'h1, 32'h0, q);
    chk("status0", 32'h96, q);
    txd <= 1'b0;
    pwm <= 1'b0;
    hcnt <= 3'h6;
    p0 <= 8'h7F;
    wb(1'b1, io_ports_pkg::IDX_IO_ONE, 4'h1, 32'hFF, q);
    waitc(4);
    chk("ctl1_set", 32'h0C, {ptx, ppw, h4, h5, hint, ext});
    hcnt <= 3'h7;
    t1 <= 1'b1;
    t2 <= 1'b1;
    @(posedge clk_i);
    t1 <= 1'b0;
    t2 <= 1'b0;
    n = 0;
    n2 = 0;
    repeat (3) begin
      @(posedge clk_i);
      if (t1i === 1'b1) n++;
      if (t2i === 1'b1) n2++;
    end
    chk("t1_irq", 32'h1, n);
    chk("t2_irq", 32'h1, n2);
    chk("hsi_int7", 32'h1, hint);
    wb(1'b1, io_ports_pkg::IDX_IO_ONE, 4'h1, 32'h0, q);
    waitc(4);
    chk("ctl1_clr", 32'h33, {ptx, ppw, h4, h5, hint, ext});
    $display("test control done");
  endtask

  task automatic t_status;
    swt <= 4'hF;
    t1 <= 1'b1;
    t2 <= 1'b1;
    full <= 1'b1;
    avail <= 1'b1;
    @(posedge clk_i);
    swt <= 4'h0;
    t1 <= 1'b0;
    t2 <= 1'b0;
    waitc(2);
    wb(1'b0, io_ports_pkg::IDX_IO_ONE, 4'h1, 32'h0, q);
    chk("status1", 32'hFF, q);
    wb(1'b0, io_ports_pkg::IDX_IO_ONE, 4'h1, 32'h0, q);
    chk("status1_clr", 32'hC0, q);
    t2 <= 1'b1;
    @(posedge clk_i);
    t2 <= 1'b0;
    waitc(2);
    wb(1'b0, io_ports_pkg::IDX_IO_ONE, 4'h1, 32'h0, q);
    chk("status1_t2", 32'hD0, q);
    $display("test status done");
  endtask

  task automatic t_ports;
    int n;
    wb(1'b1, io_ports_pkg::IDX_PORT0, 4'h1, 32'h0, q);
    wb(1'b0, io_ports_pkg::IDX_PORT0, 4'h1, 32'h0, q);
    chk("port0", 32'h7F, q);
    wb(1'b1, io_ports_pkg::IDX_PORT2, 4'h1, 32'h0, q);
    wb(1'b0, io_ports_pkg::IDX_PORT2, 4'h1, 32'h0, q);
    chk("port2_out", 32'h0, q & 32'h21);
    wb(1'b1, io_ports_pkg::IDX_ADC_SEL, 4'h1, 32'h3, q);
    conv <= 1'b1;
    @(posedge clk_i);
    conv <= 1'b0;
    n = 0;
    repeat (24) begin
      @(posedge clk_i);
      if (adcs === 8'h08) n++;
    end
    chk("sample_len", 32'h0C, n);
    $display("test ports done");
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    rst_i = 1'b1;
    {cyc, stb, we, bacc, bdrv, txd, pwm, conv, t1, t2, full, avail} = '0;
    ea_n = 1'b1;
    adr = 16'h0;
    bdat = 16'h0;
    wd = 32'h0;
    sel = 4'h0;
    swt = 4'h0;
    hcnt = 3'h0;
    p0 = 8'h00;
    st0 = 8'h00;
    extl = 8'h00;
    p2lo = 6'h3F;
    waitc(20);
    rst_i <= 1'b0;
    waitc(4);
    chk("oe_reset", 32'hFFFF, {16'h0, oen});
    chk("pull_reset", 32'h0, {22'h0, pl});
    t_quasi();
    t_shared();
    t_ctl();
    t_status();
    t_ports();
    conclude();
  end
endmodule
